// File: shared/gpib_pkg.sv
package gpib_pkg;
    // Timing
    localparam int CLK_NS = 10;
    localparam int T1_NS = 2000;
    localparam int T1_CYC = (T1_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] T1_CNT = 8'(T1_CYC);
    localparam int IFC_US = 100;
    localparam int IFC_CYC = (IFC_US * 1000 + CLK_NS - 1) / CLK_NS;

    // Bus commands, seven bits, sent with attention true
    localparam logic [6:0] CMD_GTL = 7'h01;
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_GET = 7'h08;
    localparam logic [6:0] CMD_LLO = 7'h11;
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;
    localparam logic [6:0] CMD_UNL = 7'h3F;
    localparam logic [6:0] CMD_UNT = 7'h5F;
    localparam logic [1:0] GRP_LISTEN = 2'h1;
    localparam logic [1:0] GRP_TALK = 2'h2;

    // Status byte and device options
    localparam int STB_RQS = 6;
    localparam logic LANG_SCPI = 1'b0;
    localparam logic LANG_CIIL = 1'b1;
    localparam logic CLR_SCPI = 1'b0;
    localparam logic CLR_ZERO = 1'b1;

    // Controller register map
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_TX = 12'h004;
    localparam logic [11:0] REG_RX = 12'h008;
    localparam logic [11:0] REG_STAT = 12'h00C;
    localparam logic [11:0] REG_MASK = 12'h010;
    localparam int CTRL_ATN = 0;
    localparam int CTRL_REN = 1;
    localparam int CTRL_IFC = 2;
    localparam int CTRL_LSN = 3;
    localparam int CTRL_W = 4;
    localparam int TX_EOI = 8;
    localparam int RX_EOI = 8;
    localparam int RX_VALID = 9;
    localparam int ST_TXDONE = 0;
    localparam int ST_RXBYTE = 1;
    localparam int ST_SRQ = 2;
    localparam int ST_W = 3;

    typedef enum logic [1:0] {SH_IDLE, SH_SETTLE, SH_VALID} gpib_sh_e;
    typedef enum logic [1:0] {AH_IDLE, AH_WAIT, AH_READY, AH_ACC} gpib_ah_e;
endpackage : gpib_pkg

// File: shared/gpib_bus_if.sv
`timescale 1ns/1ps
// Every line is open drain: an enable pulls the line to its true (low) level,
// so the true state of a line is the OR of all enables.
interface gpib_bus_if;
    logic [7:0] dev_dio_oe, ctl_dio_oe, dio;
    logic dev_dav_oe, ctl_dav_oe, dav;
    logic dev_nrfd_oe, ctl_nrfd_oe, nrfd;
    logic dev_ndac_oe, ctl_ndac_oe, ndac;
    logic dev_eoi_oe, ctl_eoi_oe, eoi;
    logic dev_srq_oe, srq;
    logic ctl_atn_oe, atn;
    logic ctl_ifc_oe, ifc;
    logic ctl_ren_oe, ren;

    assign dio = dev_dio_oe | ctl_dio_oe;
    assign dav = dev_dav_oe | ctl_dav_oe;
    assign nrfd = dev_nrfd_oe | ctl_nrfd_oe;
    assign ndac = dev_ndac_oe | ctl_ndac_oe;
    assign eoi = dev_eoi_oe | ctl_eoi_oe;
    assign srq = dev_srq_oe;
    assign atn = ctl_atn_oe;
    assign ifc = ctl_ifc_oe;
    assign ren = ctl_ren_oe;

    modport dev (output dev_dio_oe, dev_dav_oe, dev_nrfd_oe, dev_ndac_oe, dev_eoi_oe,
        dev_srq_oe, input dio, dav, nrfd, ndac, eoi, atn, ifc, ren);
    modport ctl (output ctl_dio_oe, ctl_dav_oe, ctl_nrfd_oe, ctl_ndac_oe, ctl_eoi_oe,
        ctl_atn_oe, ctl_ifc_oe, ctl_ren_oe, input dio, dav, nrfd, ndac, eoi, srq);
endinterface : gpib_bus_if

// File: verilog/gpib_ctl.sv
`timescale 1ns/1ps
module gpib_ctl #(
    parameter int unsigned IFC_CYC = gpib_pkg::IFC_CYC
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    gpib_bus_if.ctl bus,
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic irq_o
);
    logic [12:0] sy1_q, sy2_q;
    logic dav_s, nrfd_s, ndac_s, eoi_s, srq_s, srq_old_q;
    logic [7:0] dio_s;
    logic [gpib_pkg::CTRL_W-1:0] ctrl_q;
    logic [15:0] ifc_q;
    logic [8:0] tx_q;
    logic tx_pend_q;
    logic [7:0] rx_q;
    logic rx_eoi_q, rx_valid_q;
    logic [gpib_pkg::ST_W-1:0] stat_q, mask_q;
    logic [31:0] rdata_q;
    logic err_q;
    logic wr, rd, tx_done, take, src_act, acc_act;
    logic [7:0] cnt_q;
    gpib_pkg::gpib_sh_e sh_q;
    gpib_pkg::gpib_ah_e ah_q;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sy1_q <= '0;
            sy2_q <= '0;
        end else begin
            sy1_q <= {bus.dav, bus.nrfd, bus.ndac, bus.eoi, bus.srq, bus.dio};
            sy2_q <= sy1_q;
        end
    end
    assign {dav_s, nrfd_s, ndac_s, eoi_s, srq_s, dio_s} = sy2_q;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave; a transmit write stalls while the previous byte is pending
    assign pready_o = !(psel_i && pwrite_i && paddr_i == gpib_pkg::REG_TX && tx_pend_q);
    assign wr = psel_i && penable_i && pready_o && pwrite_i;
    assign rd = psel_i && penable_i && pready_o && !pwrite_i;
    assign prdata_o = rdata_q;
    assign pslverr_o = err_q;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= '0;
            err_q <= 1'b0;
        end else if (psel_i && !penable_i) begin
            rdata_q <= '0;
            err_q <= 1'b0;
            if (paddr_i == gpib_pkg::REG_CTRL) begin
                rdata_q <= 32'({ifc_q != 16'h0000, ctrl_q});
            end else if (paddr_i == gpib_pkg::REG_RX) begin
                rdata_q <= 32'({rx_valid_q, rx_eoi_q, rx_q});
            end else if (paddr_i == gpib_pkg::REG_STAT) begin
                rdata_q <= 32'(stat_q);
            end else if (paddr_i == gpib_pkg::REG_MASK) begin
                rdata_q <= 32'(mask_q);
            end else if (paddr_i != gpib_pkg::REG_TX) begin
                err_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= '0;
            mask_q <= '0;
        end else if (wr && paddr_i == gpib_pkg::REG_CTRL) begin
            ctrl_q <= pwdata_i[gpib_pkg::CTRL_W-1:0];
        end else if (wr && paddr_i == gpib_pkg::REG_MASK) begin
            mask_q <= pwdata_i[gpib_pkg::ST_W-1:0];
        end
    end

    // Interface clear pulse, held for the least time the bus allows
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ifc_q <= '0;
        end else if (wr && paddr_i == gpib_pkg::REG_CTRL && pwdata_i[gpib_pkg::CTRL_IFC]) begin
            ifc_q <= 16'(IFC_CYC);
        end else if (ifc_q != 16'h0000) begin
            ifc_q <= ifc_q - 16'h0001;
        end
    end
    assign bus.ctl_ifc_oe = ifc_q != 16'h0000;
    assign bus.ctl_atn_oe = ctrl_q[gpib_pkg::CTRL_ATN];
    assign bus.ctl_ren_oe = ctrl_q[gpib_pkg::CTRL_REN];

    ////////////////////////////////////////////////////////////////////////////
    // Source handshake
    assign src_act = tx_pend_q && ifc_q == 16'h0000;
    assign tx_done = sh_q == gpib_pkg::SH_VALID && !ndac_s;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tx_q <= '0;
            tx_pend_q <= 1'b0;
        end else if (wr && paddr_i == gpib_pkg::REG_TX) begin
            tx_q <= pwdata_i[8:0];
            tx_pend_q <= 1'b1;
        end else if (tx_done) begin
            tx_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sh_q <= gpib_pkg::SH_IDLE;
            cnt_q <= '0;
        end else begin
            case (sh_q)
                gpib_pkg::SH_IDLE: begin
                    cnt_q <= gpib_pkg::T1_CNT;
                    if (src_act) sh_q <= gpib_pkg::SH_SETTLE;
                end
                gpib_pkg::SH_SETTLE: begin
                    if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
                    if (!src_act) sh_q <= gpib_pkg::SH_IDLE;
                    else if (cnt_q == 8'h00 && !nrfd_s) sh_q <= gpib_pkg::SH_VALID;
                end
                default: begin
                    if (!src_act || !ndac_s) sh_q <= gpib_pkg::SH_IDLE;
                end
            endcase
        end
    end
    assign bus.ctl_dio_oe = (sh_q != gpib_pkg::SH_IDLE) ? tx_q[7:0] : 8'h00;
    assign bus.ctl_eoi_oe = sh_q != gpib_pkg::SH_IDLE && tx_q[gpib_pkg::TX_EOI];
    assign bus.ctl_dav_oe = sh_q == gpib_pkg::SH_VALID;

    ////////////////////////////////////////////////////////////////////////////
    // Acceptor handshake, active while listening with attention false
    assign acc_act = ctrl_q[gpib_pkg::CTRL_LSN] && !ctrl_q[gpib_pkg::CTRL_ATN];
    assign take = ah_q == gpib_pkg::AH_READY && dav_s;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ah_q <= gpib_pkg::AH_IDLE;
        end else begin
            case (ah_q)
                gpib_pkg::AH_IDLE: if (acc_act) ah_q <= gpib_pkg::AH_WAIT;
                gpib_pkg::AH_WAIT: begin
                    if (!acc_act) ah_q <= gpib_pkg::AH_IDLE;
                    else if (!dav_s && !rx_valid_q) ah_q <= gpib_pkg::AH_READY;
                end
                gpib_pkg::AH_READY: begin
                    if (dav_s) ah_q <= gpib_pkg::AH_ACC;
                    else if (!acc_act) ah_q <= gpib_pkg::AH_IDLE;
                end
                default: if (!dav_s) ah_q <= gpib_pkg::AH_WAIT;
            endcase
        end
    end
    assign bus.ctl_nrfd_oe = ah_q == gpib_pkg::AH_WAIT || ah_q == gpib_pkg::AH_ACC;
    assign bus.ctl_ndac_oe = ah_q == gpib_pkg::AH_WAIT || ah_q == gpib_pkg::AH_READY;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_q <= '0;
            rx_eoi_q <= 1'b0;
            rx_valid_q <= 1'b0;
        end else if (take) begin
            rx_q <= dio_s;
            rx_eoi_q <= eoi_s;
            rx_valid_q <= 1'b1;
        end else if (rd && paddr_i == gpib_pkg::REG_RX) begin
            rx_valid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky events, write one to clear; a new event wins over the clear
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            stat_q <= '0;
            srq_old_q <= 1'b0;
        end else begin
            srq_old_q <= srq_s;
            stat_q <= (stat_q & ~((wr && paddr_i == gpib_pkg::REG_STAT) ?
                pwdata_i[gpib_pkg::ST_W-1:0] : 3'h0)) | {srq_s && !srq_old_q, take, tx_done};
        end
    end
    assign irq_o = |(stat_q & mask_q);
endmodule : gpib_ctl

// File: verilog/gpib_dev.sv
`timescale 1ns/1ps
// Overview of operation
// - Full source and acceptor three-wire handshake
// - Talk on own address; listen address unaddresses
// - Listen on own address; talk address unaddresses
// - Service request line follows enabled request
// - Remote ignores panel keys except local key
// - Controller may force remote from local while remote enable is held
// - Lockout also disables local key
// - Accept universal and selected device clear
// - Bus trigger and trigger command both trigger
// - Decode addresses, poll, clear; exchange handshake
// - Bytes carry end marks; poll sends status
// - Received bytes tagged with command language
// - Clear zeroes output only in alternate mode
module gpib_dev (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    gpib_bus_if.dev bus,
    input wire logic [4:0] addr_i,
    input wire logic lang_i,
    input wire logic clr_mode_i,
    input wire logic eos_en_i,
    input wire logic [7:0] eos_char_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_end_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [7:0] rx_data_o,
    output logic rx_end_o,
    output logic rx_lang_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    input wire logic [7:0] stb_i,
    input wire logic srv_req_i,
    input wire logic trg_cmd_i,
    input wire logic key_valid_i,
    input wire logic [4:0] key_code_i,
    input wire logic key_local_i,
    output logic key_valid_o,
    output logic [4:0] key_code_o,
    output logic remote_o,
    output logic lockout_o,
    output logic talk_o,
    output logic listen_o,
    output logic dev_clr_o,
    output logic zero_out_o,
    output logic trigger_o
);
    logic [14:0] sy1_q, sy2_q;
    logic atn_s, ifc_s, ren_s, dav_s, nrfd_s, ndac_s, eoi_s;
    logic [7:0] dio_s;
    logic lsn_q, talk_q, spm_q, remote_q, llo_q, polled_q;
    logic rx_valid_q, take, cmd, acc_act, src_act, load, sent, rqs, clr;
    logic my_lsn, my_tlk, oth_tlk;
    logic [6:0] b;
    logic [7:0] dio_q, cnt_q;
    logic eoi_q, rqs_sent_q;
    gpib_pkg::gpib_sh_e sh_q;
    gpib_pkg::gpib_ah_e ah_q;

    function automatic logic addr_hit(input logic [6:0] c, input logic [1:0] grp,
        input logic [4:0] a);
        return c == {grp, a};
    endfunction : addr_hit

    // Bus lines are asynchronous to this clock
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sy1_q <= '0;
            sy2_q <= '0;
        end else begin
            sy1_q <= {bus.atn, bus.ifc, bus.ren, bus.dav, bus.nrfd, bus.ndac, bus.eoi, bus.dio};
            sy2_q <= sy1_q;
        end
    end
    assign {atn_s, ifc_s, ren_s, dav_s, nrfd_s, ndac_s, eoi_s, dio_s} = sy2_q;

    ////////////////////////////////////////////////////////////////////////////
    // Acceptor handshake; commands never wait on the data buffer
    assign acc_act = atn_s || lsn_q;
    assign take = ah_q == gpib_pkg::AH_READY && dav_s;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ah_q <= gpib_pkg::AH_IDLE;
        end else begin
            case (ah_q)
                gpib_pkg::AH_IDLE: if (acc_act) ah_q <= gpib_pkg::AH_WAIT;
                gpib_pkg::AH_WAIT: begin
                    if (!acc_act) ah_q <= gpib_pkg::AH_IDLE;
                    else if (!dav_s && (atn_s || !rx_valid_q)) ah_q <= gpib_pkg::AH_READY;
                end
                gpib_pkg::AH_READY: begin
                    if (dav_s) ah_q <= gpib_pkg::AH_ACC;
                    else if (!acc_act) ah_q <= gpib_pkg::AH_IDLE;
                end
                default: if (!dav_s) ah_q <= gpib_pkg::AH_WAIT;
            endcase
        end
    end
    assign bus.dev_nrfd_oe = ah_q == gpib_pkg::AH_WAIT || ah_q == gpib_pkg::AH_ACC;
    assign bus.dev_ndac_oe = ah_q == gpib_pkg::AH_WAIT || ah_q == gpib_pkg::AH_READY;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode, one byte per accepted handshake with attention true
    assign cmd = take && atn_s;
    assign b = dio_s[6:0];
    assign my_lsn = cmd && addr_hit(b, gpib_pkg::GRP_LISTEN, addr_i);
    assign my_tlk = cmd && addr_hit(b, gpib_pkg::GRP_TALK, addr_i);
    assign oth_tlk = cmd && b[6:5] == gpib_pkg::GRP_TALK && !my_tlk;
    assign clr = cmd && (b == gpib_pkg::CMD_DCL || (b == gpib_pkg::CMD_SDC && lsn_q));

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lsn_q <= 1'b0;
        end else if (ifc_s) begin
            lsn_q <= 1'b0;
        end else if (my_lsn) begin
            lsn_q <= 1'b1;
        end else if (my_tlk || (cmd && b == gpib_pkg::CMD_UNL)) begin
            lsn_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            talk_q <= 1'b0;
        end else if (ifc_s) begin
            talk_q <= 1'b0;
        end else if (my_tlk) begin
            talk_q <= 1'b1;
        end else if (oth_tlk || my_lsn) begin
            talk_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            spm_q <= 1'b0;
        end else if (ifc_s || (cmd && b == gpib_pkg::CMD_SPD)) begin
            spm_q <= 1'b0;
        end else if (cmd && b == gpib_pkg::CMD_SPE) begin
            spm_q <= 1'b1;
        end
    end

    // Lockout only lasts while remote enable is held; dropping it is the release
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            llo_q <= 1'b0;
        end else if (!ren_s) begin
            llo_q <= 1'b0;
        end else if (cmd && b == gpib_pkg::CMD_LLO) begin
            llo_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            remote_q <= 1'b0;
        end else if (!ren_s) begin
            remote_q <= 1'b0;
        end else if (my_lsn) begin
            remote_q <= 1'b1;
        end else if (cmd && b == gpib_pkg::CMD_GTL && lsn_q) begin
            remote_q <= 1'b0;
        end else if (key_valid_i && key_local_i && !llo_q) begin
            remote_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dev_clr_o <= 1'b0;
            zero_out_o <= 1'b0;
            trigger_o <= 1'b0;
        end else begin
            dev_clr_o <= clr;
            zero_out_o <= clr && clr_mode_i == gpib_pkg::CLR_ZERO;
            trigger_o <= (cmd && b == gpib_pkg::CMD_GET && lsn_q) || trg_cmd_i;
        end
    end

    // Panel keys pass only in local state
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            key_valid_o <= 1'b0;
            key_code_o <= '0;
        end else begin
            key_valid_o <= key_valid_i && !remote_q;
            key_code_o <= key_code_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Received data; the buffer holds one byte and stalls the acceptor when full
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_data_o <= '0;
            rx_end_o <= 1'b0;
            rx_lang_o <= gpib_pkg::LANG_SCPI;
            rx_valid_q <= 1'b0;
        end else if (take && !atn_s && lsn_q) begin
            rx_data_o <= dio_s;
            rx_end_o <= eoi_s || (eos_en_i && dio_s == eos_char_i);
            rx_lang_o <= lang_i;
            rx_valid_q <= 1'b1;
        end else if (rx_ready_i) begin
            rx_valid_q <= 1'b0;
        end
    end
    assign rx_valid_o = rx_valid_q;

    ////////////////////////////////////////////////////////////////////////////
    // Source handshake; serial poll replaces user data with the status byte
    assign src_act = talk_q && !atn_s;
    assign rqs = srv_req_i && !polled_q;
    assign tx_ready_o = sh_q == gpib_pkg::SH_IDLE && src_act && !spm_q;
    assign load = sh_q == gpib_pkg::SH_IDLE && src_act && (spm_q || tx_valid_i);
    assign sent = sh_q == gpib_pkg::SH_VALID && src_act && !ndac_s;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dio_q <= '0;
            eoi_q <= 1'b0;
            rqs_sent_q <= 1'b0;
        end else if (load && spm_q) begin
            dio_q <= {stb_i[7], rqs, stb_i[5:0]};
            eoi_q <= 1'b0;
            rqs_sent_q <= rqs;
        end else if (load) begin
            dio_q <= tx_data_i;
            eoi_q <= tx_end_i;
            rqs_sent_q <= 1'b0;
        end
    end

    // Attention aborts a byte in flight; the user byte was already taken
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sh_q <= gpib_pkg::SH_IDLE;
            cnt_q <= '0;
        end else begin
            case (sh_q)
                gpib_pkg::SH_IDLE: begin
                    cnt_q <= gpib_pkg::T1_CNT;
                    if (load) sh_q <= gpib_pkg::SH_SETTLE;
                end
                gpib_pkg::SH_SETTLE: begin
                    if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
                    if (!src_act) sh_q <= gpib_pkg::SH_IDLE;
                    else if (cnt_q == 8'h00 && !nrfd_s) sh_q <= gpib_pkg::SH_VALID;
                end
                default: begin
                    if (!src_act || !ndac_s) sh_q <= gpib_pkg::SH_IDLE;
                end
            endcase
        end
    end
    assign bus.dev_dio_oe = (sh_q != gpib_pkg::SH_IDLE) ? dio_q : 8'h00;
    assign bus.dev_eoi_oe = sh_q != gpib_pkg::SH_IDLE && eoi_q;
    assign bus.dev_dav_oe = sh_q == gpib_pkg::SH_VALID;

    ////////////////////////////////////////////////////////////////////////////
    // Service request drops once the status byte with the request bit is read
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            polled_q <= 1'b0;
        end else if (!srv_req_i) begin
            polled_q <= 1'b0;
        end else if (sent && spm_q && rqs_sent_q) begin
            polled_q <= 1'b1;
        end
    end
    assign bus.dev_srq_oe = rqs;

    // Attention and interface clear are inputs only; no parallel poll exists
    assign remote_o = remote_q;
    assign lockout_o = llo_q;
    assign talk_o = talk_q;
    assign listen_o = lsn_q;
endmodule : gpib_dev

// File: test/gpib_props.sv
`timescale 1ns/1ps
module gpib_props (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] dev_dio_oe,
    input wire logic dev_dav_oe,
    input wire logic dev_nrfd_oe,
    input wire logic dev_ndac_oe,
    input wire logic dev_eoi_oe,
    input wire logic dav,
    input wire logic nrfd,
    input wire logic ndac,
    input wire logic atn,
    input wire logic ifc
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    AST_DAV_WAIT: assert property ($rose(dev_dav_oe) |-> !nrfd) else $error("dav early");
    // Held until accepted, else a slow listener loses the byte
    AST_DAV_HOLD: assert property (dev_dav_oe && ndac && !atn && !ifc |=> dev_dav_oe)
        else $error("dav dropped");
    AST_DIO_STABLE: assert property (dev_dav_oe && $past(dev_dav_oe) |-> $stable(dev_dio_oe))
        else $error("data moved");
    AST_NDAC_TAKE: assert property ($fell(dev_ndac_oe) && dev_nrfd_oe |-> dav)
        else $error("accept without dav");
    AST_NDAC_STAY: assert property (!dev_ndac_oe && dev_nrfd_oe && dav && !ifc |=> !dev_ndac_oe)
        else $error("ndac back early");
    AST_NO_IDY: assert property (atn[*5] |-> !dev_eoi_oe) else $error("eoi under atn");
    AST_ATN_ABORT: assert property (atn[*5] |-> !dev_dav_oe) else $error("talks under atn");
    AST_IFC_QUIET: assert property (ifc[*5] |-> dev_dio_oe == 8'h00) else $error("dio in ifc");
    cover property ($rose(dev_dav_oe));
    cover property ($fell(dev_ndac_oe));
    cover property (ifc[*5]);
endmodule : gpib_props

// File: test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic core_clk_i = 0, nrst_i = 0, psel = 0, pen = 0, pwr = 0, kvi = 0, kl = 0, trg = 0;
    logic srv = 1, rxr = 0, clrm = 1, lang = 1, pready, irq, kv, clr, zo, trig, rxe, rxl, rxv;
    logic remote, lock, talk, listen, serr, txr, txv = 0;
    logic [1:0] seen = 2'h0;
    logic [4:0] adr = 5'h05, kc = 5'h03;
    logic [7:0] stb = 8'h05, rxd;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rd;
    int error_cnt = 0, comparisons = 0, cyc = 0, nclr = 0, ntrg = 0, nzo = 0;
    gpib_bus_if bus ();
    gpib_ctl #(.IFC_CYC(20)) i_gpib_ctl (.core_clk_i, .nrst_i, .bus(bus.ctl), .paddr_i(pa),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(pready), .pslverr_o(serr), .irq_o(irq));
    gpib_dev i_gpib_dev (.core_clk_i, .nrst_i, .bus(bus.dev), .addr_i(adr), .lang_i(lang),
        .clr_mode_i(clrm), .eos_en_i(1'b0), .eos_char_i(8'h00), .tx_data_i(8'hA6),
        .tx_end_i(1'b1), .tx_valid_i(txv), .tx_ready_o(txr), .rx_data_o(rxd), .rx_end_o(rxe),
        .rx_lang_o(rxl), .rx_valid_o(rxv), .rx_ready_i(rxr), .stb_i(stb), .srv_req_i(srv),
        .trg_cmd_i(trg), .key_valid_i(kvi), .key_code_i(kc), .key_local_i(kl),
        .key_valid_o(kv), .key_code_o(), .remote_o(remote), .lockout_o(lock),
        .talk_o(talk), .listen_o(listen), .dev_clr_o(clr), .zero_out_o(zo), .trigger_o(trig));
    gpib_props i_gpib_props (.core_clk_i, .nrst_i, .dev_dio_oe(bus.dev_dio_oe),
        .dev_dav_oe(bus.dev_dav_oe), .dev_nrfd_oe(bus.dev_nrfd_oe),
        .dev_ndac_oe(bus.dev_ndac_oe), .dev_eoi_oe(bus.dev_eoi_oe), .dav(bus.dav),
        .nrfd(bus.nrfd), .ndac(bus.ndac), .atn(bus.atn), .ifc(bus.ifc));
    always #5 core_clk_i = ~core_clk_i;
    // Pulses are one cycle wide, so keep a sticky record of them
    always @(posedge core_clk_i) begin
        seen <= seen | {kv, zo};
        nclr <= nclr + int'(clr);
        ntrg <= ntrg + int'(trig);
        nzo <= nzo + int'(zo);
        if (++cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Read data is taken at the edge that samples pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
        @(posedge core_clk_i);
        pen <= 1'b1;
        do @(posedge core_clk_i); while (pready !== 1'b1);
        rd = prd;
        {psel, pen} <= 2'h0;
    endtask : apb
    task automatic set_ctrl(input logic [31:0] d);
        apb(1'b1, gpib_pkg::REG_CTRL, d);
    endtask : set_ctrl
    task automatic send(input logic [8:0] b);
        apb(1'b1, gpib_pkg::REG_TX, {23'h0, b});
        rd = 32'h0;
        while (rd[0] !== 1'b1) apb(1'b0, gpib_pkg::REG_STAT, 32'h0);
        apb(1'b1, gpib_pkg::REG_STAT, 32'h1);
    endtask : send
    task automatic key(input logic l);
        repeat (4) @(posedge core_clk_i);
        {kvi, kl} <= {1'b1, l};
        @(posedge core_clk_i);
        kvi <= 1'b0;
        repeat (3) @(posedge core_clk_i);
    endtask : key
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        chk("idle", 3'h0, {remote, talk, listen});
        set_ctrl(32'h3);
        send(9'h025);
        chk("mla", 2'h3, {remote, listen});
        key(1'b0);
        send(9'h011);
        key(1'b1);
        chk("lock", 4'hC, {remote, lock, seen});
        send(9'h008);
        @(posedge core_clk_i) trg <= 1'b1;
        @(posedge core_clk_i) trg <= 1'b0;
        send(9'h004);
        chk("trig", 32'h2, ntrg);
        chk("sdc", 32'h1, nclr);
        chk("zero", 2'h1, seen);
        clrm <= 1'b0;
        set_ctrl(32'h2);
        send(9'h155);
        chk("rx", 11'h755, {rxv, rxe, rxl, rxd});
        rxr <= 1'b1;
        set_ctrl(32'h3);
        send(9'h045);
        chk("mta", 2'h2, {talk, listen});
        txv <= 1'b1;
        set_ctrl(32'hA);
        do @(posedge core_clk_i); while (txr !== 1'b1);
        txv <= 1'b0;
        rd = 32'h0;
        while (rd[9] !== 1'b1) apb(1'b0, gpib_pkg::REG_RX, 32'h0);
        chk("dab", 32'h3A6, rd);
        set_ctrl(32'h3);
        send(9'h018);
        set_ctrl(32'hA);
        rd = 32'h0;
        while (rd[9] !== 1'b1) apb(1'b0, gpib_pkg::REG_RX, 32'h0);
        chk("poll", 8'h45, rd[7:0]);
        apb(1'b0, gpib_pkg::REG_STAT, 32'h0);
        chk("srq", 2'h2, {rd[2], bus.srq});
        srv <= 1'b0;
        set_ctrl(32'h3);
        send(9'h019);
        send(9'h025);
        chk("mla", 2'h1, {talk, listen});
        send(9'h001);
        chk("gtl", 1'b0, remote);
        send(9'h014);
        chk("dcl", 32'h2, nclr);
        chk("scpi", 32'h1, nzo);
        set_ctrl(32'h7);
        repeat (40) @(posedge core_clk_i);
        chk("ifc", 1'b0, listen);
        set_ctrl(32'h0);
        key(1'b0);
        chk("local", 4'h3, {remote, lock, seen});
        apb(1'b1, gpib_pkg::REG_MASK, 32'h4);
        apb(1'b0, gpib_pkg::REG_STAT, 32'h0);
        chk("irq", 4'hE, {irq, rd[2:0]});
        apb(1'b0, 12'h014, 32'h0);
        chk("slverr", 1'b1, serr);
        apb(1'b1, gpib_pkg::REG_STAT, 32'h7);
        apb(1'b0, gpib_pkg::REG_STAT, 32'h0);
        chk("stat", 4'h0, {irq, rd[2:0]});
        report_and_stop();
    end
endmodule : tb_top
